/* core/asrc_config.sv */
// module: serial controller configuration, generators, match and pin muxes
`timescale 1ns/1ps
module asrc_config #(
  parameter int FIFO_DEPTH = 4
) (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  // avalon-mm slave
  input  wire logic [3:0]            avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  output logic      [31:0]           avs_readdata,
  output logic                       avs_waitrequest,
  // fifo fill levels
  input  wire logic [2:0]            rx_fill,
  input  wire logic [2:0]            tx_fill,
  // received character stream
  input  wire logic                  rx_valid,
  input  wire logic [8:0]            rx_char,
  // fifo and receive event outputs
  output logic                       rx_fifo_req,
  output logic                       tx_fifo_req,
  output logic                       programmed_match_flag,
  output logic                       standard_char_flag,
  output logic                       rx_store,
  output logic                       rx_fifo_locked,
  // receiver modes
  output logic                       rx_phase_lock_en,
  output logic                       sampling_window_select,
  output logic                       start_detect_select,
  // serial clock pin input
  input  wire logic                  sclk_in,
  // clock ticks and modes to tx and rx machines, generator ticks
  output logic                       rx_clk_tick,
  output logic                       rx_clock_mode,
  output logic                       tx_clk_tick,
  output logic                       tx_clock_mode,
  output logic                       gen_a_tick,
  output logic                       gen_b_tick,
  // multifunction pins (oe low = driving)
  input  wire logic                  cd_pin_in,
  output logic                       cd_pin_out,
  output logic                       cd_pin_oe_b,
  input  wire logic                  dsr_pin_in,
  output logic                       dsr_pin_out,
  output logic                       dsr_pin_oe_b,
  input  wire logic                  ring_pin_in,
  output logic                       ring_level,
  output logic                       dtr_pin_out
);
  import asrc_pkg::*;

  if (FIFO_DEPTH < 1 || FIFO_DEPTH > 7) begin
    $error("fifo depth out of range");
  end

  // configuration registers
  logic [7:0] fifo_threshold_cfg_q;  // rx/tx thresholds
  logic [7:0] char_compare_0_q;      // compare character 0
  logic [7:0] char_compare_1_q;      // compare character 1
  logic [7:0] rx_mode_q;             // receive machine mode
  logic [7:0] serial_clock_select_q; // tx/rx clock select
  logic [7:0] rate_gen_a_cfg_q;      // generator a config
  logic [7:0] rate_gen_b_cfg_q;      // generator b config
  logic [15:0] gen_a_count_q;        // generator a divisor
  logic [15:0] gen_b_count_q;        // generator b divisor
  logic [7:0] pin_function_cfg_q;    // pin direction/function
  logic [7:0] ctrl_q;                // access bit, gp outs, lock
  logic [15:0] cnt_a_q;              // generator a counter
  logic [15:0] cnt_b_q;              // generator b counter
  logic       sclk_q;                // serial clock delayed
  logic       wr;                    // write accepted
  logic       divisor_access_bit;                  // divisor access enabled
  logic       lock_set;              // hardware lock request
  logic       lock_clr;              // hardware unlock request
  logic       sclk_rise;             // serial clock edge
  logic       a_in;                  // generator a input tick
  logic       b_in;                  // generator b input tick
  logic       a_done;                // generator a terminal
  logic       b_done;                // generator b terminal
  logic       match;                 // compare register hit
  logic       std_hit;               // standard set hit

  // every access completes one cycle after request
  always_ff @(posedge clk) begin
    if (!rst_b)
      avs_waitrequest <= 1'b1;
    else
      avs_waitrequest <= !(avs_waitrequest && (avs_read || avs_write));
  end

  assign wr   = avs_write && !avs_waitrequest;
  assign divisor_access_bit = ctrl_q[CTL_DIVISOR_ACCESS_BIT];

  // configuration writes
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      fifo_threshold_cfg_q  <= RST_FIFO_THR;
      char_compare_0_q      <= RST_ZERO;
      char_compare_1_q      <= RST_ZERO;
      rx_mode_q             <= RST_RX_MODE;
      serial_clock_select_q <= RST_CLK_SEL;
      rate_gen_a_cfg_q      <= RST_GEN_A;
      rate_gen_b_cfg_q      <= RST_GEN_B;
      gen_a_count_q         <= {RST_ZERO, RST_ZERO};
      gen_b_count_q         <= {RST_ZERO, RST_ZERO};
      pin_function_cfg_q    <= RST_PIN_CFG;
    end else if (wr) begin
      if (avs_address == ADDR_FIFO_THR)
        fifo_threshold_cfg_q <= avs_writedata[7:0];
      else if (avs_address == ADDR_CMP0)
        char_compare_0_q <= avs_writedata[7:0];
      else if (avs_address == ADDR_CMP1)
        char_compare_1_q <= avs_writedata[7:0];
      else if (avs_address == ADDR_RX_MODE)
        rx_mode_q <= avs_writedata[7:0];
      else if (avs_address == ADDR_CLK_SEL)
        serial_clock_select_q <= avs_writedata[7:0];
      else if (avs_address == ADDR_GEN_A_CFG)
        rate_gen_a_cfg_q <= avs_writedata[7:0];
      else if (avs_address == ADDR_GEN_B_CFG)
        rate_gen_b_cfg_q <= avs_writedata[7:0];
      else if (avs_address == ADDR_A_LOW && divisor_access_bit)
        gen_a_count_q[7:0] <= avs_writedata[7:0];
      else if (avs_address == ADDR_A_HIGH && divisor_access_bit)
        gen_a_count_q[15:8] <= avs_writedata[7:0];
      else if (avs_address == ADDR_B_LOW && divisor_access_bit)
        gen_b_count_q[7:0] <= avs_writedata[7:0];
      else if (avs_address == ADDR_B_HIGH && divisor_access_bit)
        gen_b_count_q[15:8] <= avs_writedata[7:0];
      else if (avs_address == ADDR_PIN_CFG)
        pin_function_cfg_q <= avs_writedata[7:0];
    end
  end

  // control register; hardware lock changes win over software
  always_ff @(posedge clk) begin
    if (!rst_b)
      ctrl_q <= RST_ZERO;
    else begin
      if (wr && avs_address == ADDR_CTRL)
        ctrl_q <= avs_writedata[7:0];
      if (lock_set)
        ctrl_q[CTL_LOCK] <= 1'b1;
      else if (lock_clr)
        ctrl_q[CTL_LOCK] <= 1'b0;
    end
  end

  // read mux; unmapped and locked-out addresses read zero
  always_ff @(posedge clk) begin
    if (!rst_b)
      avs_readdata <= 32'h0000_0000;
    else if (avs_read && avs_waitrequest) begin
      avs_readdata <= 32'h0000_0000;
      if (avs_address == ADDR_FIFO_THR)
        avs_readdata[7:0] <= fifo_threshold_cfg_q;
      else if (avs_address == ADDR_CMP0)
        avs_readdata[7:0] <= char_compare_0_q;
      else if (avs_address == ADDR_CMP1)
        avs_readdata[7:0] <= char_compare_1_q;
      else if (avs_address == ADDR_RX_MODE)
        avs_readdata[7:0] <= rx_mode_q;
      else if (avs_address == ADDR_CLK_SEL)
        avs_readdata[7:0] <= serial_clock_select_q;
      else if (avs_address == ADDR_GEN_A_CFG)
        avs_readdata[7:0] <= rate_gen_a_cfg_q;
      else if (avs_address == ADDR_GEN_B_CFG)
        avs_readdata[7:0] <= rate_gen_b_cfg_q;
      else if (avs_address == ADDR_A_LOW && divisor_access_bit)
        avs_readdata[7:0] <= gen_a_count_q[7:0];
      else if (avs_address == ADDR_A_HIGH && divisor_access_bit)
        avs_readdata[7:0] <= gen_a_count_q[15:8];
      else if (avs_address == ADDR_B_LOW && divisor_access_bit)
        avs_readdata[7:0] <= gen_b_count_q[7:0];
      else if (avs_address == ADDR_B_HIGH && divisor_access_bit)
        avs_readdata[7:0] <= gen_b_count_q[15:8];
      else if (avs_address == ADDR_PIN_CFG)
        avs_readdata[7:0] <= pin_function_cfg_q;
      else if (avs_address == ADDR_CTRL)
        avs_readdata[7:0] <= ctrl_q;
      else if (avs_address == ADDR_STATUS)
        avs_readdata[7:0] <= {2'b00, ring_level, dsr_pin_in, cd_pin_in,
                              rx_fifo_locked, tx_fifo_req, rx_fifo_req};
    end
  end

  // fifo threshold requests
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rx_fifo_req <= 1'b0;
      tx_fifo_req <= 1'b0;
    end else begin
      rx_fifo_req <= rx_fill >
        {1'b0, fifo_threshold_cfg_q[RX_THR_LSB +: 2]};
      tx_fifo_req <= tx_fill <=
        {1'b0, fifo_threshold_cfg_q[TX_THR_LSB +: 2]};
    end
  end

  // character compare and standard set recognition
  always_comb begin
    match = (rx_char[7:0] == char_compare_0_q) ||
            (rx_char[7:0] == char_compare_1_q);
    case (rx_mode_q[RXM_REC_LSB +: 2])
      REC_ASCII: std_hit = rx_char[7:0] <= ASCII_TOP ||
                           rx_char[7:0] == ASCII_DEL;
      REC_EBCD:  std_hit = rx_char[7:0] <= EBCD_TOP;
      default:   std_hit = 1'b0;
    endcase
  end

  // network lock control on address characters
  always_comb begin
    lock_set = 1'b0;
    lock_clr = 1'b0;
    if (rx_valid && rx_mode_q[RXM_NET] && rx_char[8]) begin
      if (rx_mode_q[RXM_REC_LSB +: 2] == REC_ASCII)
        lock_clr = 1'b1;
      else if (rx_mode_q[RXM_REC_LSB +: 2] == REC_AUTO) begin
        lock_clr = match;
        lock_set = !match;
      end
    end
  end

  // receive flags, one-cycle pulses per character
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      programmed_match_flag <= 1'b0;
      standard_char_flag    <= 1'b0;
      rx_store              <= 1'b0;
    end else if (!rx_valid) begin
      programmed_match_flag <= 1'b0;
      standard_char_flag    <= 1'b0;
      rx_store              <= 1'b0;
    end else if (rx_mode_q[RXM_NET]) begin
      programmed_match_flag <= rx_char[8] && match;
      standard_char_flag    <= rx_char[8] &&
        rx_mode_q[RXM_REC_LSB +: 2] != REC_EBCD;
      // address chars always stored except in automatic mismatch
      if (rx_char[8])
        rx_store <= !lock_set;
      else
        rx_store <= !ctrl_q[CTL_LOCK];
    end else begin
      programmed_match_flag <= match;
      standard_char_flag    <= std_hit || match;
      rx_store              <= 1'b1;
    end
  end

  // receiver mode and clock mode outputs
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rx_fifo_locked         <= 1'b0;
      rx_phase_lock_en       <= 1'b1;
      sampling_window_select <= 1'b0;
      start_detect_select    <= 1'b0;
      rx_clock_mode          <= 1'b0;
      tx_clock_mode          <= 1'b0;
    end else begin
      rx_fifo_locked         <= ctrl_q[CTL_LOCK];
      rx_phase_lock_en       <= !rx_mode_q[RXM_DPD];
      sampling_window_select <= rx_mode_q[RXM_SWM];
      start_detect_select    <= rx_mode_q[RXM_SSM];
      rx_clock_mode <= serial_clock_select_q[CLK_RXM];
      tx_clock_mode <= serial_clock_select_q[CLK_TXM];
    end
  end

  // generator input selection
  assign sclk_rise = sclk_in && !sclk_q;
  always_comb begin
    // timer mode always counts system clock
    if (!rate_gen_a_cfg_q[GA_MODE])
      a_in = 1'b1;
    else
      a_in = rate_gen_a_cfg_q[GA_SRC] ? sclk_rise : 1'b1;
    if (!rate_gen_b_cfg_q[GB_MODE])
      b_in = 1'b1;
    else if (rate_gen_b_cfg_q[GB_SRC_LSB +: 2] == GB_PIN)
      b_in = sclk_rise;
    else if (rate_gen_b_cfg_q[GB_SRC_LSB +: 2] == GB_GENA)
      b_in = gen_a_tick;
    else
      b_in = rate_gen_b_cfg_q[GB_SRC_LSB +: 2] == GB_SYS;
  end
  assign a_done = a_in && cnt_a_q == 16'h0000;
  assign b_done = b_in && cnt_b_q == 16'h0000;

  // 16-bit down counters reload from divisor
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cnt_a_q    <= 16'h0000;
      cnt_b_q    <= 16'h0000;
      sclk_q     <= 1'b0;
      gen_a_tick <= 1'b0;
      gen_b_tick <= 1'b0;
    end else begin
      sclk_q     <= sclk_in;
      gen_a_tick <= a_done;
      gen_b_tick <= b_done;
      if (a_done)
        cnt_a_q <= gen_a_count_q;
      else if (a_in)
        cnt_a_q <= cnt_a_q - 16'h0001;
      if (b_done)
        cnt_b_q <= gen_b_count_q;
      else if (b_in)
        cnt_b_q <= cnt_b_q - 16'h0001;
    end
  end

  // tx/rx clock ticks: 16x from generator, 1x from pin
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rx_clk_tick <= 1'b0;
      tx_clk_tick <= 1'b0;
    end else begin
      if (serial_clock_select_q[CLK_RXM])
        rx_clk_tick <= sclk_rise;
      else
        rx_clk_tick <= serial_clock_select_q[CLK_RXS] ? a_done : b_done;
      if (serial_clock_select_q[CLK_TXM])
        tx_clk_tick <= sclk_rise;
      else
        tx_clk_tick <= serial_clock_select_q[CLK_TXS] ? a_done : b_done;
    end
  end

  // multifunction pin drivers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cd_pin_out   <= 1'b0;
      cd_pin_oe_b  <= 1'b1;
      dsr_pin_out  <= 1'b0;
      dsr_pin_oe_b <= 1'b1;
      ring_level   <= 1'b0;
      dtr_pin_out  <= 1'b0;
    end else begin
      cd_pin_oe_b  <= pin_function_cfg_q[PIN_CD_DIR];
      cd_pin_out   <= pin_function_cfg_q[PIN_CD_FN] ?
                      ctrl_q[CTL_GP_OUT_1] : clk;
      dsr_pin_oe_b <= pin_function_cfg_q[PIN_DSR_DIR];
      dsr_pin_out  <= pin_function_cfg_q[PIN_DSR_FN] ?
                      ctrl_q[CTL_GP_OUT_0] : a_done;
      ring_level   <= pin_function_cfg_q[PIN_RI_FN] &&
                      ring_pin_in;
      dtr_pin_out  <= pin_function_cfg_q[PIN_DTR_FN] ?
                      ctrl_q[CTL_DTR] : b_done;
    end
  end

endmodule

/* core/asrc_pkg.sv */
// package: register map, fields and reset values of the serial config
// Behaviour
// - rx fifo request when fill above threshold
// - tx fifo request when fill at/below threshold
// - normal mode: compare each character, report match
// - network mode: only address characters compared
// - code 00 flags address chars, stores them
// - code 01 also unlocks fifo on address
// - code 10 unlocks on match, locks mismatch
// - normal mode standard set: none, ascii, ebcdic
// - disable bit turns phase lock loop off
// - window bit picks 3/16 or 7/16 sampling
// - start bit majority vote or all zero
// - rx clock 16x from generator, or 1x pin
// - tx clock 16x from generator, or 1x pin
// - generator a source ignored in timer mode
// - mode bit 0 timer on system clock
// - generator b source field, no effect timer
// - each generator uses 16-bit count
// - direction 0 output, function 0 special
// - carrier pin: input, clock out, or gp
// - dsr pin: input, generator a, or gp
// - ring pin clock/ring (code: function 0 only forces ring_level low); dtr pin gen b/dtr
// - count bytes reachable only with divisor access
package asrc_pkg;
  // register word addresses (byte address = index * 4)
  localparam logic [3:0] ADDR_FIFO_THR  = 4'h0;
  localparam logic [3:0] ADDR_CMP0      = 4'h1;
  localparam logic [3:0] ADDR_CMP1      = 4'h2;
  localparam logic [3:0] ADDR_RX_MODE   = 4'h3;
  localparam logic [3:0] ADDR_CLK_SEL   = 4'h4;
  localparam logic [3:0] ADDR_GEN_A_CFG = 4'h5;
  localparam logic [3:0] ADDR_GEN_B_CFG = 4'h6;
  localparam logic [3:0] ADDR_A_LOW     = 4'h7;
  localparam logic [3:0] ADDR_A_HIGH    = 4'h8;
  localparam logic [3:0] ADDR_B_LOW     = 4'h9;
  localparam logic [3:0] ADDR_B_HIGH    = 4'hA;
  localparam logic [3:0] ADDR_PIN_CFG   = 4'hB;
  localparam logic [3:0] ADDR_CTRL      = 4'hC;
  localparam logic [3:0] ADDR_STATUS    = 4'hD;
  // field positions
  localparam int RX_THR_LSB   = 0;
  localparam int TX_THR_LSB   = 4;
  localparam int RXM_DPD      = 0;
  localparam int RXM_SWM      = 1;
  localparam int RXM_SSM      = 2;
  localparam int RXM_NET      = 3;
  localparam int RXM_REC_LSB  = 4;
  localparam int CLK_RXM      = 0;
  localparam int CLK_RXS      = 1;
  localparam int CLK_TXM      = 2;
  localparam int CLK_TXS      = 3;
  localparam int GA_SRC       = 0;
  localparam int GA_MODE      = 1;
  localparam int GB_SRC_LSB   = 6;
  localparam int GB_MODE      = 3;
  localparam int PIN_CD_DIR   = 7;
  localparam int PIN_CD_FN    = 6;
  localparam int PIN_DSR_DIR  = 5;
  localparam int PIN_DSR_FN   = 4;
  localparam int PIN_RI_FN    = 3;
  localparam int PIN_DTR_FN   = 2;
  localparam int CTL_DIVISOR_ACCESS_BIT     = 0;
  localparam int CTL_GP_OUT_0     = 1;
  localparam int CTL_GP_OUT_1     = 2;
  localparam int CTL_DTR      = 3;
  localparam int CTL_LOCK     = 4;
  // reset values
  localparam logic [7:0] RST_FIFO_THR = 8'h00;
  localparam logic [7:0] RST_RX_MODE  = 8'h00;
  localparam logic [7:0] RST_CLK_SEL  = 8'h00;
  localparam logic [7:0] RST_GEN_A    = 8'h04;
  localparam logic [7:0] RST_GEN_B    = 8'h84;
  localparam logic [7:0] RST_PIN_CFG  = 8'hFC;
  localparam logic [7:0] RST_ZERO     = 8'h00;
  // recognition codes
  localparam logic [1:0] REC_NONE  = 2'h0;
  localparam logic [1:0] REC_ASCII = 2'h1;
  localparam logic [1:0] REC_AUTO  = 2'h2;
  localparam logic [1:0] REC_EBCD  = 2'h3;
  // standard character bounds
  localparam logic [7:0] ASCII_TOP = 8'h1F;
  localparam logic [7:0] ASCII_DEL = 8'h7F;
  localparam logic [7:0] EBCD_TOP  = 8'h3F;
  // generator b source codes
  localparam logic [1:0] GB_SYS  = 2'h0;
  localparam logic [1:0] GB_PIN  = 2'h1;
  localparam logic [1:0] GB_GENA = 2'h2;
endpackage

/* dv/asrc_config_props.sv */
// checker: properties on the serial config block ports
`timescale 1ns/1ps
module asrc_config_props (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // register bus
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // fifo levels and characters
  input wire logic [2:0]  rx_fill,
  input wire logic [2:0]  tx_fill,
  input wire logic        rx_valid,
  input wire logic [8:0]  rx_char,
  // outputs under watch
  input wire logic        rx_fifo_req,
  input wire logic        tx_fifo_req,
  input wire logic        programmed_match_flag,
  input wire logic        standard_char_flag,
  input wire logic        rx_phase_lock_en,
  input wire logic        sampling_window_select,
  input wire logic        start_detect_select,
  input wire logic        rx_clock_mode,
  input wire logic        tx_clock_mode
);
  import asrc_pkg::*;
  logic [7:0] sh_q [16]; // shadow of what software wrote
  logic [1:0] qt_q;      // edges since last write
  wire logic  wr_ok = avs_write && !avs_waitrequest; // write taken
  // mirror accepted writes; all zero after reset except pin config
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sh_q <= '{default: 8'h00};
      sh_q[ADDR_PIN_CFG] <= RST_PIN_CFG;
    end else if (wr_ok) begin
      sh_q[avs_address] <= avs_writedata[7:0];
    end
  end
  // settle counter for copied config bits
  always_ff @(posedge clk) begin
    if (!rst_b || wr_ok) begin
      qt_q <= 2'h0;
    end else if (qt_q != 2'h3) begin
      qt_q <= qt_q + 2'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  AST_RX_REQ: assert property ($past(rst_b) && !$past(wr_ok) |->
    rx_fifo_req == $past(rx_fill > {1'b0, sh_q[ADDR_FIFO_THR][1:0]}))
    else $error("rx fifo request wrong");
  AST_TX_REQ: assert property ($past(rst_b) && !$past(wr_ok) |->
    tx_fifo_req == $past(tx_fill <= {1'b0, sh_q[ADDR_FIFO_THR][5:4]}))
    else $error("tx fifo request wrong");
  AST_ONE_WAIT: assert property ((avs_read || avs_write) &&
    avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one cycle");
  AST_MATCH: assert property (rx_valid && !sh_q[ADDR_RX_MODE][3]
    && (rx_char[7:0] == sh_q[ADDR_CMP0] || rx_char[7:0] == sh_q[ADDR_CMP1])
    |=> programmed_match_flag) else $error("programmed match missed");
  AST_NET_DATA: assert property (rx_valid && sh_q[ADDR_RX_MODE][3]
    && !rx_char[8] |=> !programmed_match_flag)
    else $error("data char compared in network mode");
  AST_QUIET: assert property (!rx_valid |=>
    !programmed_match_flag && !standard_char_flag)
    else $error("flag without a character");
  AST_ASCII: assert property (rx_valid &&
    sh_q[ADDR_RX_MODE][5:3] == 3'h2 &&
    (rx_char[7:0] <= ASCII_TOP || rx_char[7:0] == ASCII_DEL)
    |=> standard_char_flag) else $error("ascii control missed");
  AST_RX_MODES: assert property (qt_q == 2'h3 |->
    rx_phase_lock_en == !sh_q[ADDR_RX_MODE][0] &&
    {start_detect_select, sampling_window_select} ==
    sh_q[ADDR_RX_MODE][2:1]) else $error("receiver mode copy wrong");
  AST_CLK_MODES: assert property (qt_q == 2'h3 |->
    rx_clock_mode == sh_q[ADDR_CLK_SEL][0] &&
    tx_clock_mode == sh_q[ADDR_CLK_SEL][2])
    else $error("clock mode copy wrong");
  AST_HIDDEN: assert property (avs_read && !avs_waitrequest &&
    avs_address inside {[4'h7:4'hA]} && !sh_q[ADDR_CTRL][0]
    |-> avs_readdata == 32'h0) else $error("count read without access");
  CV_MATCH: cover property (rx_valid ##1 programmed_match_flag);
  CV_STD: cover property (rx_valid ##1 standard_char_flag);
  CV_REQ: cover property (rx_fifo_req && tx_fifo_req);
endmodule

/* dv/asrc_remote.sv */
// far side model: character source, serial clock and modem pin levels
`timescale 1ns/1ps
module asrc_remote (
  // clock and bench controls
  input  wire logic  clk,
  input  wire logic  sclk_run,
  input  wire logic  cd_far,
  input  wire logic  ring_far,
  // character stream into the block
  output logic       rx_valid,
  output logic [8:0] rx_char,
  // serial clock pin
  output logic       sclk_in,
  // multifunction pins
  input  wire logic  cd_pin_out,
  input  wire logic  cd_pin_oe_b,
  input  wire logic  dsr_pin_out,
  input  wire logic  dsr_pin_oe_b,
  output logic       cd_pin_in,
  output logic       dsr_pin_in,
  output logic       ring_pin_in
);
  initial {rx_valid, rx_char, sclk_in} = '0;
  // far end drives only while the block listens
  assign cd_pin_in = cd_pin_oe_b ? cd_far : cd_pin_out;
  assign dsr_pin_in = dsr_pin_oe_b ? ~cd_far : dsr_pin_out;
  assign ring_pin_in = ring_far;
  // serial clock toggles once a cycle while running
  always @(posedge clk) begin
    if (sclk_run) begin
      sclk_in <= ~sclk_in;
    end
  end
  // one character; afterwards the line shows the inverse
  task automatic send(input logic [8:0] c);
    @(posedge clk);
    rx_char <= c;
    rx_valid <= 1'b1;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_char <= ~c;
  endtask
endmodule

/* dv/asrc_config_tb_top.sv */
// bench top: drives the configuration block by bus and far side
`timescale 1ns/1ps
module asrc_config_tb_top;
  import asrc_pkg::*;
  // design and model connections
  logic clk, rst_b, avs_read, avs_write, rx_valid, sclk_in, sclk_run;
  logic avs_waitrequest, rx_fifo_req, tx_fifo_req, rx_store;
  logic programmed_match_flag, standard_char_flag, rx_fifo_locked;
  logic rx_phase_lock_en, sampling_window_select, start_detect_select;
  logic rx_clk_tick, rx_clock_mode, tx_clk_tick, tx_clock_mode;
  logic gen_a_tick, gen_b_tick, cd_pin_in, cd_pin_out, cd_pin_oe_b;
  logic dsr_pin_in, dsr_pin_out, dsr_pin_oe_b, ring_pin_in, ring_level;
  logic dtr_pin_out, cd_far, ring_far;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [2:0]  rx_fill, tx_fill;
  logic [8:0]  rx_char;
  int          n_fail, num_checks, na, nb, nr, nt;
  asrc_config uut (.*);
  asrc_remote rem (.*);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // generator and tx/rx clock tick counters
  always @(posedge clk) begin
    na += (gen_a_tick === 1'b1);
    nb += (gen_b_tick === 1'b1);
    nr += (rx_clk_tick === 1'b1);
    nt += (tx_clk_tick === 1'b1);
  end
  task automatic report_and_stop;
    if (n_fail == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t got %h expected %h", $time, g, e);
    end
  endtask
  // one bus access, held until waitrequest is low
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [7:0] d);
    int n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= w;
    avs_read <= !w;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    n_fail += (n == 50);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic sw;
    repeat (3) @(posedge clk);
    #1;
  endtask
  // settle, then count ticks over whole periods
  task automatic cnt(input int s, input int w);
    repeat (s) @(posedge clk);
    #1;
    {na, nb, nr, nt} = '0;
    repeat (w) @(posedge clk);
    #1;
  endtask
  task automatic t_regs;
    logic [3:0] ad [8];
    logic [7:0] ex [8];
    ad = '{ADDR_FIFO_THR, ADDR_RX_MODE, ADDR_CLK_SEL, ADDR_GEN_A_CFG,
           ADDR_GEN_B_CFG, ADDR_PIN_CFG, ADDR_A_LOW, 4'hF};
    ex = '{RST_FIFO_THR, RST_RX_MODE, RST_CLK_SEL, RST_GEN_A, RST_GEN_B,
           RST_PIN_CFG, RST_ZERO, RST_ZERO};
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, ad[i], 8'h00);
      chk(q, {24'h0, ex[i]});
    end
  endtask
  task automatic t_fifo;
    logic [7:0] th [2];
    th = '{8'h12, 8'h30};
    for (int k = 0; k < 2; k++) begin
      bus(1'b1, ADDR_FIFO_THR, th[k]);
      for (int f = 0; f < 5; f++) begin
        rx_fill <= 3'(f);
        tx_fill <= 3'(f);
        sw();
        chk(rx_fifo_req, f > th[k][1:0]);
        chk(tx_fifo_req, f <= th[k][5:4]);
      end
    end
  endtask
  task automatic t_chars;
    logic [18:0] tb [10]; // mode, character, {match, standard}
    tb = '{{8'h10, 9'h015, 2'h3}, {8'h10, 9'h07F, 2'h1},
           {8'h10, 9'h020, 2'h0}, {8'h10, 9'h01F, 2'h1},
           {8'h00, 9'h07F, 2'h0}, {8'h00, 9'h0A5, 2'h3},
           {8'h30, 9'h03F, 2'h1}, {8'h30, 9'h040, 2'h0},
           {8'h08, 9'h1A5, 2'h3}, {8'h08, 9'h0A5, 2'h0}};
    bus(1'b1, ADDR_CMP0, 8'h15);
    bus(1'b1, ADDR_CMP1, 8'hA5);
    for (int i = 0; i < 10; i++) begin
      bus(1'b1, ADDR_RX_MODE, tb[i][18:11]);
      rem.send(tb[i][10:2]);
      #1;
      chk({programmed_match_flag, standard_char_flag},
          tb[i][1:0]);
    end
    bus(1'b1, ADDR_RX_MODE, 8'h07);
    sw();
    chk({rx_phase_lock_en, sampling_window_select, start_detect_select},
        3'h3);
  endtask
  task automatic lk(input logic [8:0] c, input logic e);
    rem.send(c);
    sw();
    chk(rx_fifo_locked, e);
  endtask
  task automatic t_lock;
    bus(1'b1, ADDR_RX_MODE, 8'h28);
    lk(9'h133, 1'b1);
    rem.send(9'h041);
    #1;
    chk(rx_store, 1'b0);
    lk(9'h115, 1'b0);
    bus(1'b1, ADDR_CTRL, 8'h10);
    bus(1'b1, ADDR_RX_MODE, 8'h18);
    lk(9'h133, 1'b0);
    bus(1'b1, ADDR_RX_MODE, 8'h08);
    rem.send(9'h133);
    #1;
    chk(rx_store, 1'b1);
  endtask
  task automatic t_gens;
    bus(1'b1, ADDR_CTRL, 8'h01);
    bus(1'b1, ADDR_A_LOW, 8'h03);
    bus(1'b1, ADDR_GEN_A_CFG, 8'h02);
    cnt(20, 40);
    chk(na, 32'hA);
    bus(1'b1, ADDR_GEN_A_CFG, 8'h03);
    cnt(20, 40);
    chk(na, 32'h0);
    sclk_run <= 1'b1;
    cnt(20, 40);
    chk(na, 32'h5);
    sclk_run <= 1'b0;
    bus(1'b1, ADDR_GEN_A_CFG, 8'h01);
    cnt(20, 40);
    chk(na, 32'hA);
    bus(1'b1, ADDR_GEN_A_CFG, 8'h02);
    bus(1'b1, ADDR_B_LOW, 8'h01);
    bus(1'b1, ADDR_GEN_B_CFG, 8'h88);
    bus(1'b1, ADDR_CLK_SEL, 8'h02);
    cnt(20, 40);
    chk({nb[7:0], nr[7:0], nt[7:0]}, 24'h050A05);
    bus(1'b1, ADDR_GEN_B_CFG, 8'h80);
    cnt(20, 40);
    chk(nb, 32'h14);
    bus(1'b1, ADDR_A_HIGH, 8'h01);
    bus(1'b1, ADDR_A_LOW, 8'h00);
    cnt(300, 514);
    chk(na, 32'h2);
    bus(1'b1, ADDR_CLK_SEL, 8'h05);
    sw();
    chk({rx_clock_mode, tx_clock_mode}, 2'h3);
    bus(1'b1, ADDR_CTRL, 8'h00);
    bus(1'b1, ADDR_A_LOW, 8'h55);
    bus(1'b1, ADDR_CTRL, 8'h01);
    bus(1'b0, ADDR_A_LOW, 8'h00);
    chk(q, 32'h0);
  endtask
  task automatic t_pins;
    bus(1'b1, ADDR_PIN_CFG, 8'h5C);
    bus(1'b1, ADDR_CTRL, 8'h0A);
    ring_far <= 1'b1;
    sw();
    chk({cd_pin_oe_b, dsr_pin_oe_b, cd_pin_out, dsr_pin_out, dtr_pin_out,
         ring_level}, 6'h07);
    bus(1'b1, ADDR_PIN_CFG, 8'h00);
    sw();
    chk({cd_pin_oe_b, dsr_pin_oe_b, cd_pin_out}, 3'h1);
    cd_far <= 1'b1;
    bus(1'b1, ADDR_PIN_CFG, 8'hFC);
    sw();
    chk({cd_pin_oe_b, dsr_pin_oe_b}, 2'h3);
    bus(1'b0, ADDR_STATUS, 8'h00);
    chk(q[4:3], 2'h1);
  endtask
  initial begin
    {rst_b, avs_read, avs_write, sclk_run, cd_far, ring_far} = '0;
    {avs_address, avs_writedata, rx_fill, tx_fill} = '0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    t_regs();
    t_fifo();
    t_chars();
    t_lock();
    t_gens();
    t_pins();
    report_and_stop();
  end
  // hang guard, far beyond the run's length
  initial begin
    #(4 * 20000);
    n_fail++;
    report_and_stop();
  end
endmodule
bind asrc_config asrc_config_props prop_chk (.*);
